// ==== hw/sdocfg_consts.vh ====
// constants for the serial output and output word configuration block
`ifndef SDOCFG_CONSTS_VH
`define SDOCFG_CONSTS_VH

// ===============================
// register byte offsets
`define SDOCFG_OFS_INPUT_CFG 8'h08
`define SDOCFG_OFS_SERIAL_OUT_CFG 8'h0c
`define SDOCFG_OFS_WORD_CFG 8'h10
// pattern registers are kept as word indices; byte address is four times the index
`define SDOCFG_IDX_PAT_LOW 8'h14
`define SDOCFG_IDX_PAT_MID 8'h15
`define SDOCFG_IDX_PAT_TOP 8'h16
`define SDOCFG_OFS_RESULT 8'h80
`define SDOCFG_OFS_STATUS 8'h84
`define SDOCFG_OFS_START 8'h88

// ===============================
// reset values
`define SDOCFG_RST_SERIAL_OUT_CFG 8'h00
`define SDOCFG_RST_WORD_CFG 8'h00
`define SDOCFG_RST_INPUT_CFG 8'h00

// ===============================
// write masks (reserved bits never stored)
`define SDOCFG_MASK_SERIAL_OUT_CFG 8'hdf
`define SDOCFG_MASK_WORD_CFG 8'h0f
`define SDOCFG_MASK_INPUT_CFG 8'h03
`define SDOCFG_MASK_PAT_TOP 8'h0f

// ===============================
// encodings
`define SDOCFG_PROTO_PLAIN 2'h0
`define SDOCFG_PROTO_EARLY 2'h1
`define SDOCFG_PROTO_BAD 2'h2
`define SDOCFG_PROTO_SRCSYNC 2'h3
`define SDOCFG_CLK_ECHO 2'h0
`define SDOCFG_CLK_INT 2'h1
`define SDOCFG_CLK_INT2 2'h2
`define SDOCFG_CLK_INT4 2'h3

// ===============================
// frame widths
`define SDOCFG_WORD_BITS 22
`define SDOCFG_PAYLOAD_BITS 20

`endif

// ==== hw/sdocfg_shift.v ====
// serial output shifter: lanes, data rate, early launch, clock source
`timescale 1ns/1ps
`default_nettype none
`include "sdocfg_consts.vh"

module sdocfg_shift (
	// clock and reset
	input wire clk_sys,
	input wire sys_rst,
	// synchronised link
	input wire cs_n,
	input wire sclk,
	// configuration
	input wire [7:0] out_cfg,
	input wire [1:0] in_mode,
	input wire [21:0] word,
	// outputs
	output reg [3:0] sdo_reg,
	output reg rclk_reg,
	output reg busy_reg
);
	reg sclk_d;
	reg cs_d;
	reg [21:0] sh_reg;
	reg skip_reg;
	reg [1:0] pre_reg;
	reg prim;
	wire [1:0] proto;
	wire [1:0] lanes;
	wire cpol;
	wire cpha;
	wire ddr;
	wire rise;
	wire fall;
	wire lead;
	wire trail;
	wire launch;
	wire startf;
	wire [2:0] step;

	assign proto = out_cfg[1:0];
	assign lanes = out_cfg[3:2];
	assign cpol = in_mode[1];
	assign cpha = in_mode[0];
	// data rate bit only counts outside the plain protocol
	assign ddr = (proto != `SDOCFG_PROTO_PLAIN) & out_cfg[4];
	assign rise = sclk & ~sclk_d;
	assign fall = ~sclk & sclk_d;
	assign lead = cpol ? fall : rise;
	assign trail = cpol ? rise : fall;
	assign startf = cs_d & ~cs_n;
	assign step = (lanes == 2'h3) ? 3'h4 : ((lanes == 2'h2) ? 3'h2 : 3'h1);

	// internal output clock tick for source-synchronous mode
	always @* begin
		case (out_cfg[7:6])
		`SDOCFG_CLK_INT: prim = 1'b1;
		`SDOCFG_CLK_INT2: prim = (pre_reg[0] == 1'b1);
		`SDOCFG_CLK_INT4: prim = (pre_reg == 2'h3);
		default: prim = 1'b0;
		endcase
	end

	// early launch moves the update onto the leading edge
	assign launch = (proto == `SDOCFG_PROTO_SRCSYNC) ?
		((out_cfg[7:6] == `SDOCFG_CLK_ECHO) ? (ddr ? (rise | fall) : rise) :
		(prim & (ddr | ~rclk_reg))) :
		(proto == `SDOCFG_PROTO_EARLY) ? (ddr ? (rise | fall) : lead) :
		(cpha ? lead : trail);

	always @(posedge clk_sys) begin
		if (sys_rst) begin
			sclk_d <= 1'b0;
			cs_d <= 1'b1;
			sh_reg <= 22'h000000;
			skip_reg <= 1'b0;
			pre_reg <= 2'h0;
			sdo_reg <= 4'h0;
			rclk_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else begin
			sclk_d <= sclk;
			cs_d <= cs_n;
			pre_reg <= pre_reg + 2'h1;
			if (cs_n) begin
				busy_reg <= 1'b0;
				rclk_reg <= 1'b0;
			end else if (startf) begin
				busy_reg <= 1'b1;
				sh_reg <= word;
				sdo_reg <= {word[18], word[19], word[20], word[21]};
				// a phase-1 host samples on trailing edges, so the msb outlives the first lead
				skip_reg <= ~proto[0] & cpha;
			end else if (launch && busy_reg && skip_reg) begin
				skip_reg <= 1'b0;
			end else if (launch && busy_reg) begin
				sh_reg <= sh_reg << step;
				sdo_reg <= (lanes == 2'h3) ? {sh_reg[14], sh_reg[15], sh_reg[16], sh_reg[17]} :
					(lanes == 2'h2) ? {2'b00, sh_reg[18], sh_reg[19]} :
					{3'b000, sh_reg[20]};
				if (proto == `SDOCFG_PROTO_SRCSYNC) begin
					rclk_reg <= (out_cfg[7:6] == `SDOCFG_CLK_ECHO) ? sclk : ~rclk_reg;
				end
			end else if (proto == `SDOCFG_PROTO_SRCSYNC && prim && busy_reg) begin
				rclk_reg <= ~rclk_reg;
			end
		end
	end
endmodule // sdocfg_shift
`default_nettype wire

// ==== hw/sdocfg_top.v ====
// serial output configuration block with axi4-lite register slave
// ===============================
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "sdocfg_consts.vh"

module sdocfg_top (
	// clock and reset
	input wire clk_sys,
	input wire sys_rst,
	// axi4-lite write address
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// axi4-lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read address
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// axi4-lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// serial link from the host
	input wire link_cs_n,
	input wire link_sclk,
	// serial link to the host
	output reg [3:0] sdo_lane_reg,
	output reg out_clk_reg
);
	// ===============================
	// registers
	reg [7:0] serial_output_config_reg;
	reg [7:0] output_word_config_reg;
	reg [7:0] serial_input_config_reg;
	reg [7:0] pattern_low_byte_reg;
	reg [7:0] pattern_middle_byte_reg;
	reg [7:0] pattern_top_nibble_reg;
	reg [19:0] result_reg;
	reg [7:0] aw_addr_reg;
	reg aw_have_reg;
	reg [31:0] w_data_reg;
	reg [3:0] w_strb_reg;
	reg w_have_reg;
	reg cs_m_reg;
	reg cs_s_reg;
	reg sclk_m_reg;
	reg sclk_s_reg;
	reg [31:0] rd_next;
	reg rd_ok;
	reg wr_ok;
	wire [21:0] word;
	wire [3:0] sdo;
	wire rclk;
	wire busy;
	wire do_write;
	wire [7:0] wbyte;

	// byte address of a register kept as an index
	function [7:0] idx_addr;
		input [7:0] idx;
		begin
			idx_addr = {idx[5:0], 2'b00};
		end
	endfunction

	// merge byte lane 0 under its strobe and a field mask
	function [7:0] merge8;
		input [7:0] old;
		input [7:0] data;
		input strb;
		input [7:0] mask;
		begin
			merge8 = strb ? (data & mask) : old;
		end
	endfunction

	// ===============================
	// link synchronisers: first stage is read only by the second
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			cs_m_reg <= 1'b1;
			cs_s_reg <= 1'b1;
			sclk_m_reg <= 1'b0;
			sclk_s_reg <= 1'b0;
		end else begin
			cs_m_reg <= link_cs_n;
			cs_s_reg <= cs_m_reg;
			sclk_m_reg <= link_sclk;
			sclk_s_reg <= sclk_m_reg;
		end
	end

	// ===============================
	// axi4-lite write side: address and data taken in either order
	assign do_write = aw_have_reg & w_have_reg & ~s_axi_bvalid;
	assign wbyte = w_data_reg[7:0];

	always @* begin
		case (aw_addr_reg)
		`SDOCFG_OFS_SERIAL_OUT_CFG, `SDOCFG_OFS_WORD_CFG, `SDOCFG_OFS_INPUT_CFG,
		`SDOCFG_OFS_START, `SDOCFG_OFS_RESULT: wr_ok = 1'b1;
		default: wr_ok = (aw_addr_reg == idx_addr(`SDOCFG_IDX_PAT_LOW)) |
			(aw_addr_reg == idx_addr(`SDOCFG_IDX_PAT_MID)) |
			(aw_addr_reg == idx_addr(`SDOCFG_IDX_PAT_TOP));
		endcase
	end

	always @(posedge clk_sys) begin
		if (sys_rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			serial_output_config_reg <= `SDOCFG_RST_SERIAL_OUT_CFG;
			output_word_config_reg <= `SDOCFG_RST_WORD_CFG;
			serial_input_config_reg <= `SDOCFG_RST_INPUT_CFG;
			pattern_low_byte_reg <= 8'h00;
			pattern_middle_byte_reg <= 8'h00;
			pattern_top_nibble_reg <= 8'h00;
			result_reg <= 20'h00000;
		end else begin
			s_axi_awready <= ~aw_have_reg & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready <= ~w_have_reg & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_reg <= 1'b1;
				aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (do_write) begin
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
				// reserved bits are masked so they always read zero
				if (aw_addr_reg == `SDOCFG_OFS_SERIAL_OUT_CFG) begin
					serial_output_config_reg <= merge8(serial_output_config_reg, wbyte,
						w_strb_reg[0], `SDOCFG_MASK_SERIAL_OUT_CFG);
				end
				if (aw_addr_reg == `SDOCFG_OFS_WORD_CFG) begin
					output_word_config_reg <= merge8(output_word_config_reg, wbyte,
						w_strb_reg[0], `SDOCFG_MASK_WORD_CFG);
				end
				if (aw_addr_reg == `SDOCFG_OFS_INPUT_CFG) begin
					serial_input_config_reg <= merge8(serial_input_config_reg, wbyte,
						w_strb_reg[0], `SDOCFG_MASK_INPUT_CFG);
				end
				if (aw_addr_reg == idx_addr(`SDOCFG_IDX_PAT_LOW)) begin
					pattern_low_byte_reg <= merge8(pattern_low_byte_reg, wbyte,
						w_strb_reg[0], 8'hff);
				end
				if (aw_addr_reg == idx_addr(`SDOCFG_IDX_PAT_MID)) begin
					pattern_middle_byte_reg <= merge8(pattern_middle_byte_reg, wbyte,
						w_strb_reg[0], 8'hff);
				end
				if (aw_addr_reg == idx_addr(`SDOCFG_IDX_PAT_TOP)) begin
					pattern_top_nibble_reg <= merge8(pattern_top_nibble_reg, wbyte,
						w_strb_reg[0], `SDOCFG_MASK_PAT_TOP);
				end
				// stands in for the converter output, which lives elsewhere
				if (aw_addr_reg == `SDOCFG_OFS_RESULT) begin
					result_reg <= w_data_reg[19:0];
				end
			end
		end
	end

	// ===============================
	// axi4-lite read side
	always @* begin
		rd_ok = 1'b1;
		case ({2'b00, s_axi_araddr[7:2]})
		`SDOCFG_OFS_SERIAL_OUT_CFG >> 2: rd_next = {24'h000000, serial_output_config_reg};
		`SDOCFG_OFS_WORD_CFG >> 2: rd_next = {24'h000000, output_word_config_reg};
		`SDOCFG_OFS_INPUT_CFG >> 2: rd_next = {24'h000000, serial_input_config_reg};
		`SDOCFG_IDX_PAT_LOW: rd_next = {24'h000000, pattern_low_byte_reg};
		`SDOCFG_IDX_PAT_MID: rd_next = {24'h000000, pattern_middle_byte_reg};
		`SDOCFG_IDX_PAT_TOP: rd_next = {24'h000000, pattern_top_nibble_reg};
		`SDOCFG_OFS_RESULT >> 2: rd_next = {12'h000, result_reg};
		`SDOCFG_OFS_STATUS >> 2: rd_next = {9'h000, busy, word};
		default: begin
			rd_next = 32'h00000000;
			rd_ok = 1'b0;
		end
		endcase
	end

	always @(posedge clk_sys) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end else begin
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_next;
				s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ===============================
	// datapath
	sdocfg_word u_word (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.word_cfg(output_word_config_reg),
		.pattern({pattern_top_nibble_reg[3:0], pattern_middle_byte_reg,
			pattern_low_byte_reg}),
		.result(result_reg),
		.word_reg(word)
	);

	// protocol 10b is left to the host to avoid; it behaves like 00b here
	sdocfg_shift u_shift (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.cs_n(cs_s_reg),
		.sclk(sclk_s_reg),
		.out_cfg(serial_output_config_reg),
		.in_mode(serial_input_config_reg[1:0]),
		.word(word),
		.sdo_reg(sdo),
		.rclk_reg(rclk),
		.busy_reg(busy)
	);

	always @(posedge clk_sys) begin
		if (sys_rst) begin
			sdo_lane_reg <= 4'h0;
			out_clk_reg <= 1'b0;
		end else begin
			sdo_lane_reg <= sdo;
			out_clk_reg <= rclk;
		end
	end
endmodule // sdocfg_top
`default_nettype wire

// ==== hw/sdocfg_word.v ====
// output word composer: payload select and even parity
`timescale 1ns/1ps
`default_nettype none
`include "sdocfg_consts.vh"

module sdocfg_word (
	// clock and reset
	input wire clk_sys,
	input wire sys_rst,
	// configuration
	input wire [7:0] word_cfg,
	input wire [19:0] pattern,
	input wire [19:0] result,
	// composed word
	output reg [21:0] word_reg
);
	wire [19:0] payload;
	wire [1:0] span;
	reg partial;
	reg [21:0] word_next;

	assign payload = word_cfg[0] ? pattern : result;
	assign span = word_cfg[3:2];

	// even parity is the xor of the covered bits
	always @* begin
		case (span)
		2'h0: partial = ^payload[19:16];
		2'h1: partial = ^payload[19:12];
		2'h2: partial = ^payload[19:8];
		default: partial = ^payload[19:4];
		endcase
		if (word_cfg[1]) begin
			word_next = {payload, ^payload, partial};
		end else begin
			word_next = {payload, 2'b00};
		end
	end

	always @(posedge clk_sys) begin
		if (sys_rst) begin
			word_reg <= 22'h000000;
		end else begin
			word_reg <= word_next;
		end
	end
endmodule // sdocfg_word
`default_nettype wire

// ==== tb/sdocfg_host.sv ====
// host controller model: frame select, serial clock, lane capture
`timescale 1ns/1ps
`default_nettype none

module sdocfg_host (
	// link to the device
	output logic link_cs_n,
	output logic link_sclk,
	input wire logic [3:0] sdo_lane_reg,
	input wire logic out_clk_reg
);
	logic [21:0] ga;
	logic [21:0] gb;
	int oc;
	initial begin
		link_cs_n = 1'h1;
		link_sclk = 1'h0;
		oc = 0;
	end
	always @(posedge out_clk_reg) begin
		oc++;
	end
	// lane 0 carries the oldest bit of each beat
	function automatic logic [21:0] cap(input logic [21:0] g, input int w, input logic [3:0] l);
		case (w)
		4: return {g[17:0], l[0], l[1], l[2], l[3]};
		2: return {g[19:0], l[0], l[1]};
		default: return {g[20:0], l[0]};
		endcase
	endfunction
	// ====
	// one frame; offset of 1 ns keeps link edges off the system clock edges
	task automatic frame(input logic cp, input int w, input int n);
		link_sclk = cp;
		#41;
		oc = 0;
		link_cs_n = 1'h0;
		#40;
		repeat (n) begin
			link_sclk = !cp;
			ga = cap(ga, w, sdo_lane_reg);
			#16;
			link_sclk = cp;
			gb = cap(gb, w, sdo_lane_reg);
			#16;
		end
		link_cs_n = 1'h1;
		#40;
	endtask
endmodule // sdocfg_host

`default_nettype wire

// ==== tb/sdocfg_monitor.sv ====
// bus and link checker bound to the serial output configuration block
`timescale 1ns/1ps
`default_nettype none

module sdocfg_monitor (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// serial link
	input wire logic link_cs_n,
	input wire logic [3:0] sdo_lane_reg,
	input wire logic out_clk_reg
);
	// ====
	// sequences
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence cs_idle;
		link_cs_n [*8];
	endsequence
	// ====
	// assertions
	a_aw_answer: assert property (s_axi_awvalid && !s_axi_awready && !s_axi_bvalid |=> s_axi_awready)
		else $error("write address not accepted in time");
	a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("write address ready held too long");
	a_w_pulse: assert property (s_axi_wready |=> !s_axi_wready)
		else $error("write data ready held too long");
	a_b_answer: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
		else $error("write response missing");
	a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
		else $error("read data missing");
	a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	a_lanes_hold_idle: assert property (cs_idle |-> $stable(sdo_lane_reg))
		else $error("lanes moved outside a frame");
	a_outclk_idle: assert property (cs_idle |-> !out_clk_reg)
		else $error("output clock runs outside a frame");
endmodule // sdocfg_monitor

bind sdocfg_top sdocfg_monitor sdocfg_monitor_i (
	.clk_sys(clk_sys),
	.sys_rst(sys_rst),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.link_cs_n(link_cs_n),
	.sdo_lane_reg(sdo_lane_reg),
	.out_clk_reg(out_clk_reg)
);

`default_nettype wire

// ==== tb/sdocfg_top_tb.sv ====
// self-checking bench for the serial output configuration block
`timescale 1ns/1ps
`default_nettype none

module sdocfg_top_tb;
	logic clk_sys = 1'h0;
	logic sys_rst = 1'h1;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'h0;
	logic s_axi_wvalid = 1'h0;
	logic s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0;
	logic s_axi_rready = 1'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	wire logic link_cs_n, link_sclk, out_clk_reg;
	wire logic [3:0] sdo_lane_reg;
	int miscompares = 0;
	int total_checks = 0;
	logic [19:0] res = 20'h6b2d1;
	logic [19:0] pat = 20'h93ca5;
	logic [21:0] e;
	logic [21:0] x;
	always #2 clk_sys = !clk_sys;
	sdocfg_top sdocfg_top_i (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.link_cs_n(link_cs_n),
		.link_sclk(link_sclk),
		.sdo_lane_reg(sdo_lane_reg),
		.out_clk_reg(out_clk_reg)
	);
	sdocfg_host sdocfg_host_i (
		.link_cs_n(link_cs_n),
		.link_sclk(link_sclk),
		.sdo_lane_reg(sdo_lane_reg),
		.out_clk_reg(out_clk_reg)
	);
	// ====
	// helpers
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		total_checks++;
		if (g !== x) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, g, x);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	function automatic logic [21:0] wexp(input logic [7:0] c, input logic [19:0] r, input logic [19:0] p);
		logic [19:0] d;
		logic [15:0] m;
		d = c[0] ? p : r;
		m = d[19:4] & (16'hffff << (12 - 4 * c[3:2]));
		return {d, c[1] & ^d, c[1] & ^m};
	endfunction
	// ====
	// bus master; ready stands from the request until the answer is seen, and one edge
	// passes after each transfer so no signal is driven twice in one time step
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
		chk({30'h0, s_axi_bresp}, {30'h0, er});
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
		chk(s_axi_rdata, x);
		chk({30'h0, s_axi_rresp}, {30'h0, er});
		@(posedge clk_sys);
	endtask
	task automatic link(input logic [7:0] oc, input logic [7:0] im, input int w, input logic cp,
		input int n);
		wr(8'h0c, {24'h0, oc}, 2'h0);
		wr(8'h08, {24'h0, im}, 2'h0);
		@(posedge clk_sys);
		sdocfg_host_i.frame(cp, w, n);
	endtask
	// ====
	// tests
	initial begin
		#200000;
		miscompares++;
		complete_run();
	end
	initial begin
		repeat (8) @(posedge clk_sys);
		sys_rst <= 1'h0;
		@(posedge clk_sys);
		rd(8'h0c, 32'h0, 2'h0);
		rd(8'h10, 32'h0, 2'h0);
		wr(8'h0c, 32'hdf, 2'h0);
		rd(8'h0c, 32'hdf, 2'h0);
		wr(8'h10, 32'hff, 2'h0);
		rd(8'h10, 32'h0f, 2'h0);
		wr(8'h40, 32'h5a, 2'h2);
		rd(8'h40, 32'h0, 2'h2);
		$display("register test done");
		wr(8'h80, {12'h0, res}, 2'h0);
		wr(8'h50, 32'ha5, 2'h0);
		wr(8'h54, 32'h3c, 2'h0);
		wr(8'h58, 32'hf9, 2'h0);
		rd(8'h58, 32'h09, 2'h0);
		for (int c = 0; c < 16; c++) begin
			wr(8'h10, c, 2'h0);
			rd(8'h84, {10'h0, wexp(c[7:0], res, pat)}, 2'h0);
		end
		$display("word test done");
		wr(8'h10, 32'h02, 2'h0);
		e = wexp(8'h02, res, pat);
		link(8'h00, 8'h00, 1, 1'h0, 22);
		chk(sdocfg_host_i.ga, e);
		chk(sdocfg_host_i.gb, e);
		chk(sdocfg_host_i.oc, 0);
		link(8'h10, 8'h00, 1, 1'h0, 22);
		chk(sdocfg_host_i.ga, e);
		link(8'h00, 8'h02, 1, 1'h1, 22);
		chk(sdocfg_host_i.ga, e);
		link(8'h00, 8'h01, 1, 1'h0, 22);
		chk(sdocfg_host_i.gb, e);
		link(8'h01, 8'h00, 1, 1'h0, 22);
		chk(sdocfg_host_i.gb[21:1], e[20:0]);
		// double rate: one bit per host edge, leading edges take the odd positions
		link(8'h11, 8'h00, 1, 1'h0, 11);
		for (int i = 0; i < 11; i++) begin
			x[21 - 2 * i] = sdocfg_host_i.ga[10 - i];
			x[20 - 2 * i] = sdocfg_host_i.gb[10 - i];
		end
		chk(x, e);
		link(8'h08, 8'h00, 2, 1'h0, 11);
		chk(sdocfg_host_i.ga, e);
		// six beats of four lanes: the last beat ends in two padding zeros
		link(8'h0c, 8'h00, 4, 1'h0, 6);
		chk(sdocfg_host_i.ga, {e[19:0], 2'h0});
		link(8'h43, 8'h00, 1, 1'h0, 22);
		chk(sdocfg_host_i.oc > 0, 1);
		$display("link test done");
		complete_run();
	end
endmodule // sdocfg_top_tb

`default_nettype wire
